// *** verilog/pidc_pkg.sv ***
package pidc_pkg;
  // sample path widths
  localparam int unsigned PIDC_DATA_W = 24;
  localparam int unsigned PIDC_ADC_W = 18;
  localparam int unsigned PIDC_DAC_W = 18;
  localparam int unsigned PIDC_COEF_W = 16;
  localparam int unsigned PIDC_FRAC_W = 12;
  // loop rate
  localparam int unsigned PIDC_CLK_HZ = 20000000;
  localparam int unsigned PIDC_SAMPLE_HZ = 50000;
  localparam int unsigned PIDC_SAMPLE_CYC = PIDC_CLK_HZ / PIDC_SAMPLE_HZ;
  // reset values of the gain registers
  localparam logic [15:0] PIDC_PGAIN_RST = 16'h1000;
  localparam logic [15:0] PIDC_ITC_RST = 16'h0000;
  localparam logic [15:0] PIDC_DTC_RST = 16'h0000;
  // low-pass smoothing shift per stage
  localparam int unsigned PIDC_LP_SHIFT = 3;
  localparam int unsigned PIDC_LP_ORDER = 4;
  typedef enum logic [0:0] {PIDC_SHAPE_SLEW, PIDC_SHAPE_LOWPASS} pidc_shape_e;
  typedef enum {PIDC_IDLE, PIDC_SHAPE, PIDC_NOTCH, PIDC_ERR, PIDC_TERMS,
                PIDC_SUM} pidc_state_e;
endpackage

// *** verilog/pidc_lowpass.sv ***
`timescale 1ns/1ns
// cascade of first-order sections; every section updates per enable pulse
module pidc_lowpass
  import pidc_pkg::*;
#(
  parameter int unsigned W = PIDC_DATA_W,
  parameter int unsigned ORDER = PIDC_LP_ORDER,
  parameter int unsigned SHIFT = PIDC_LP_SHIFT
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // sample stream
  input wire logic step_i,
  input wire logic signed [W-1:0] x_i,
  output logic signed [W-1:0] y_o
);
  if (ORDER < 1 || SHIFT >= W)
  begin : g_bad_param
    $error("pidc_lowpass: bad parameters");
  end

  logic signed [W-1:0] stage [ORDER];
  logic signed [W-1:0] src [ORDER];
  logic signed [W:0] diff [ORDER];

  for (genvar g = 0; g < ORDER; g++)
  begin : g_sec
    if (g == 0)
    begin : g_first
      assign src[g] = x_i;
    end
    else
    begin : g_next
      assign src[g] = stage[g-1];
    end
    assign diff[g] = {src[g][W-1], src[g]} - {stage[g][W-1], stage[g]};
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        stage[g] <= '0;
      else if (step_i)
        stage[g] <= stage[g] + W'(diff[g] >>> SHIFT);
    end
  end

  assign y_o = stage[ORDER-1];
endmodule

// *** verilog/pidc_core.sv ***
`timescale 1ns/1ns
// Behaviour
// - setpoint is offset input sample plus digital set value
// - command shaped by slew limit or fourth-order low-pass, by config
// - deviation is shaped, optionally notched command minus sensor feedback each sample
// - proportional output is deviation times proportional gain
// - integral step is deviation times sample period over time constant
// - derivative is time constant over period times deviation change
// - loop output is sum of proportional, integral, derivative
// - open loop passes shaped, optionally notched command straight to the output
// - notch filter switchable in closed and open loop
// - gains load from actuator id memory on connect, user may override
// - 24-bit signal path at 50 kSa loop rate
// - output delivered as an 18-bit converter word
// - function generator mode forces offset input off
// - switch enables or disables the offset input
module pidc_core
  import pidc_pkg::*;
#(
  parameter int unsigned ADC_W = PIDC_ADC_W,
  parameter int unsigned SAMPLE_CYC = PIDC_SAMPLE_CYC
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // converter samples, valid pulse marks a fresh pair
  input wire logic adc_valid_i,
  input wire logic [ADC_W-1:0] sensor_i,
  input wire logic [ADC_W-1:0] external_analog_offset_input_i,
  // digital command and mode
  input wire logic signed [PIDC_DATA_W-1:0] set_value_i,
  input wire logic offset_enable_i,
  input wire logic func_gen_active_i,
  input wire logic closed_loop_i,
  input wire logic notch_enable_i,
  input wire logic shape_lowpass_i,
  input wire logic [PIDC_DATA_W-1:0] slew_step_i,
  // notch coefficient, fraction of the PIDC_FRAC_W scale
  input wire logic signed [PIDC_COEF_W-1:0] notch_coef_i,
  // gains: user writes and actuator id defaults
  input wire logic [PIDC_COEF_W-1:0] proportional_gain_i,
  input wire logic [PIDC_COEF_W-1:0] integral_time_constant_i,
  input wire logic [PIDC_COEF_W-1:0] derivative_time_constant_i,
  input wire logic gain_write_i,
  input wire logic id_load_i,
  input wire logic [PIDC_COEF_W-1:0] id_proportional_gain_i,
  input wire logic [PIDC_COEF_W-1:0] id_integral_time_constant_i,
  input wire logic [PIDC_COEF_W-1:0] id_derivative_time_constant_i,
  // outputs
  output logic [PIDC_DAC_W-1:0] dac_data_o,
  output logic dac_valid_o,
  output logic signed [PIDC_DATA_W-1:0] deviation_o,
  output logic sample_tick_o
);
  localparam int unsigned DW = PIDC_DATA_W;
  localparam int unsigned AW = DW + PIDC_COEF_W + 2;
  localparam int unsigned CNT_W = $clog2(SAMPLE_CYC + 1);

  if (ADC_W != 18 && ADC_W != 20)
  begin : g_bad_adc_w
    $error("pidc_core: converter width must be 18 or 20");
  end
  if (SAMPLE_CYC < 8)
  begin : g_bad_rate
    $error("pidc_core: sample period too short for the pipeline");
  end

  // clamp instead of wrap, so an overflow never flips the drive polarity
  function automatic logic signed [DW-1:0] sat(input logic signed [AW-1:0] v);
    logic signed [AW-1:0] hi;
    logic signed [AW-1:0] lo;
    hi = AW'({1'b0, {(DW-1){1'b1}}});
    lo = -hi - AW'(1);
    if (v > hi)
      sat = hi[DW-1:0];
    else if (v < lo)
      sat = lo[DW-1:0];
    else
      sat = v[DW-1:0];
  endfunction

  // unsigned converter word widened to the signed path
  function automatic logic signed [DW-1:0] widen(input logic [ADC_W-1:0] s);
    widen = DW'({1'b0, s, {(DW-1-ADC_W){1'b0}}});
  endfunction

  // three-stage capture of the converter strobe; a level counts once the
  // second and third stages agree, so a one-cycle glitch never fires
  logic [2:0] vld_sync;
  logic vld_level;
  logic [ADC_W-1:0] sens_hold;
  logic [ADC_W-1:0] off_hold;
  logic sample_go;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vld_sync <= '0;
      vld_level <= 1'b0;
    end
    else
    begin
      vld_sync <= {vld_sync[1:0], adc_valid_i};
      if (vld_sync[1] == vld_sync[2])
        vld_level <= vld_sync[2];
    end
  end
  assign sample_go = vld_sync[2] && vld_sync[1] && !vld_level;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sens_hold <= '0;
      off_hold <= '0;
    end
    else if (sample_go)
    begin
      sens_hold <= sensor_i;
      off_hold <= external_analog_offset_input_i;
    end
  end

  // free running 50 kSa tick from the 20 MHz clock
  // the loop works on the last captured pair, so converter jitter never
  // moves the loop timing
  logic [CNT_W-1:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == CNT_W'(SAMPLE_CYC - 1));
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt <= '0;
    else if (tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + CNT_W'(1);
  end

  // gain registers; a user write wins over an id load in the same cycle,
  // so a connect event in that same cycle never undoes an explicit setting
  logic [PIDC_COEF_W-1:0] kprop;
  logic [PIDC_COEF_W-1:0] tint;
  logic [PIDC_COEF_W-1:0] tder;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      kprop <= PIDC_PGAIN_RST;
      tint <= PIDC_ITC_RST;
      tder <= PIDC_DTC_RST;
    end
    else if (gain_write_i)
    begin
      kprop <= proportional_gain_i;
      tint <= integral_time_constant_i;
      tder <= derivative_time_constant_i;
    end
    else if (id_load_i)
    begin
      kprop <= id_proportional_gain_i;
      tint <= id_integral_time_constant_i;
      tder <= id_derivative_time_constant_i;
    end
  end

  // setpoint
  wire offset_on = offset_enable_i && !func_gen_active_i;
  wire signed [DW-1:0] off_term = offset_on ? widen(off_hold) : '0;
  wire signed [DW-1:0] setpoint =
    sat(AW'(off_term) + AW'(set_value_i));

  // command shaping
  logic signed [DW-1:0] slew_cmd;
  logic signed [DW-1:0] lp_cmd;
  logic shape_step;
  wire signed [AW-1:0] slew_diff = AW'(setpoint) - AW'(slew_cmd);
  wire signed [AW-1:0] slew_lim = AW'({1'b0, slew_step_i});
  wire signed [DW-1:0] next_slew_cmd =
    (slew_diff > slew_lim) ? sat(AW'(slew_cmd) + slew_lim) :
    (slew_diff < -slew_lim) ? sat(AW'(slew_cmd) - slew_lim) : setpoint;
  wire signed [DW-1:0] shaped = shape_lowpass_i ? lp_cmd : slew_cmd;

  pidc_lowpass #(
    .W(DW),
    .ORDER(PIDC_LP_ORDER),
    .SHIFT(PIDC_LP_SHIFT)
  ) u_lowpass (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .step_i(shape_step),
    .x_i(setpoint),
    .y_o(lp_cmd)
  );

  // notch: subtract scaled second difference of the shaped command
  logic signed [DW-1:0] cmd_d1;
  logic signed [DW-1:0] cmd_d2;
  logic signed [DW-1:0] notched;
  wire signed [AW-1:0] second_diff =
    AW'(shaped) - (AW'(cmd_d1) <<< 1) + AW'(cmd_d2);
  wire signed [AW+PIDC_COEF_W-1:0] notch_prod = second_diff * notch_coef_i;
  wire signed [DW-1:0] notch_out =
    sat(AW'(AW'(shaped) - AW'(notch_prod >>> PIDC_FRAC_W)));

  // pid terms
  logic signed [DW-1:0] deviation;
  logic signed [DW-1:0] prev_dev;
  logic signed [DW-1:0] prop_out;
  logic signed [DW-1:0] integ_acc;
  logic signed [DW-1:0] deriv_out;
  wire signed [AW-1:0] dev_w = AW'(notched) - AW'(widen(sens_hold));
  wire signed [AW-1:0] p_prod =
    AW'((deviation * $signed({1'b0, kprop})) >>> PIDC_FRAC_W);
  // period over time constant is held as a reciprocal fraction
  wire signed [AW-1:0] i_step =
    AW'((deviation * $signed({1'b0, tint})) >>> PIDC_FRAC_W);
  wire signed [AW-1:0] dev_delta = AW'(deviation) - AW'(prev_dev);
  // time constant over period comes in already scaled by the rate
  wire signed [AW-1:0] d_prod =
    AW'((dev_delta * $signed({1'b0, tder})) >>> PIDC_FRAC_W);
  wire signed [AW-1:0] pid_sum =
    AW'(prop_out) + AW'(integ_acc) + AW'(deriv_out);
  wire signed [DW-1:0] loop_out =
    closed_loop_i ? sat(pid_sum) : notched;
  // offset binary for the converter, top bits only
  wire [DW-1:0] dac_full = {~loop_out[DW-1], loop_out[DW-2:0]};

  pidc_state_e state;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= PIDC_IDLE;
      slew_cmd <= '0;
      shape_step <= 1'b0;
      cmd_d1 <= '0;
      cmd_d2 <= '0;
      notched <= '0;
      deviation <= '0;
      prev_dev <= '0;
      prop_out <= '0;
      integ_acc <= '0;
      deriv_out <= '0;
      dac_data_o <= '0;
      dac_valid_o <= 1'b0;
      deviation_o <= '0;
      sample_tick_o <= 1'b0;
    end
    else
    begin
      shape_step <= 1'b0;
      dac_valid_o <= 1'b0;
      sample_tick_o <= tick;
      case (state)
        PIDC_IDLE:
          if (tick)
          begin
            slew_cmd <= next_slew_cmd;
            shape_step <= 1'b1;
            state <= PIDC_SHAPE;
          end
        PIDC_SHAPE:
          state <= PIDC_NOTCH;
        PIDC_NOTCH:
        begin
          notched <= notch_enable_i ? notch_out : shaped;
          cmd_d1 <= shaped;
          cmd_d2 <= cmd_d1;
          state <= PIDC_ERR;
        end
        PIDC_ERR:
        begin
          prev_dev <= deviation;
          deviation <= sat(dev_w);
          state <= PIDC_TERMS;
        end
        PIDC_TERMS:
        begin
          prop_out <= sat(p_prod);
          deriv_out <= sat(d_prod);
          // cleared in open loop so closing the loop starts without windup
          if (closed_loop_i)
            integ_acc <= sat(AW'(integ_acc) + i_step);
          else
            integ_acc <= '0;
          state <= PIDC_SUM;
        end
        PIDC_SUM:
        begin
          dac_data_o <= dac_full[DW-1 -: PIDC_DAC_W];
          dac_valid_o <= 1'b1;
          deviation_o <= deviation;
          state <= PIDC_IDLE;
        end
        default:
          state <= PIDC_IDLE;
      endcase
    end
  end
endmodule

// *** dv/pidc_adc_model.sv ***
`timescale 1ns/1ns
// converter in front of the loop: strobes every 10 cycles, data held
// around the strobe only, so a late capture sees inverted lines
module pidc_adc_model
  import pidc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // values to convert
  input wire logic [PIDC_ADC_W-1:0] sensor_i,
  input wire logic [PIDC_ADC_W-1:0] offset_i,
  // converter lines
  output logic adc_valid_o,
  output logic [PIDC_ADC_W-1:0] sensor_o,
  output logic [PIDC_ADC_W-1:0] offset_o
);
  logic [3:0] cnt;
  wire logic hold = cnt < 4'h8;
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt <= 4'h0;
    else
      cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
  assign adc_valid_o = rst_n_i && cnt inside {[4'h1:4'h5]};
  assign sensor_o = hold ? sensor_i : ~sensor_i;
  assign offset_o = hold ? offset_i : ~offset_i;
endmodule

// *** dv/pidc_core_sva.sv ***
`timescale 1ns/1ns
module pidc_core_sva
  import pidc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = PIDC_SAMPLE_CYC
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // outputs under watch
  input wire logic [PIDC_DAC_W-1:0] dac_data_o,
  input wire logic dac_valid_o,
  input wire logic signed [PIDC_DATA_W-1:0] deviation_o,
  input wire logic sample_tick_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // cycles since the last tick, zero until the first one
  int unsigned since;
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      since <= 0;
    else
      since <= sample_tick_o ? 1 : since + (since != 0);
  property p_gap;
    since != 0 |-> sample_tick_o == (since == SAMPLE_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("tick gap");
  property p_tick;
    sample_tick_o |=> !sample_tick_o;
  endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  property p_lat;
    $rose(sample_tick_o) |-> ##[5:6] dac_valid_o;
  endproperty
  a_lat: assert property (p_lat) else $error("no output");
  property p_cause;
    dac_valid_o |-> since inside {[5:6]};
  endproperty
  a_cause: assert property (p_cause) else $error("stray out");
  property p_vw;
    dac_valid_o |=> !dac_valid_o;
  endproperty
  a_vw: assert property (p_vw) else $error("valid width");
  property p_dac;
    $changed(dac_data_o) |-> dac_valid_o;
  endproperty
  a_dac: assert property (p_dac) else $error("dac moved");
  property p_dev;
    $changed(deviation_o) |-> dac_valid_o;
  endproperty
  a_dev: assert property (p_dev) else $error("dev moved");
  property p_ovl;
    dac_valid_o |-> !sample_tick_o;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overlap");
endmodule
bind pidc_core pidc_core_sva #(.SAMPLE_CYC(SAMPLE_CYC)) i_sva (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .dac_data_o(dac_data_o),
  .dac_valid_o(dac_valid_o), .deviation_o(deviation_o),
  .sample_tick_o(sample_tick_o));

// *** dv/pid_position_controller_tb_top.sv ***
`timescale 1ns/1ns
module pid_position_controller_tb_top;
  import pidc_pkg::*;
  localparam int unsigned CYC = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic av, cl, lp, oe, fg, ne, gw, il, dv, tk;
  logic [17:0] sn, of, asn, aof, dac, pd;
  logic signed [23:0] sv, dev, s;
  logic [23:0] ss;
  logic [15:0] nc, pgn, itc, dtc, igp, iit, idt;
  int miscompares = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  pidc_adc_model i_adc (.mclk_i(clk), .rst_n_i(rst_n), .sensor_i(sn),
    .offset_i(of), .adc_valid_o(av), .sensor_o(asn), .offset_o(aof));
  pidc_core #(.SAMPLE_CYC(CYC)) i_dut (
    .mclk_i(clk), .rst_n_i(rst_n), .adc_valid_i(av), .sensor_i(asn),
    .external_analog_offset_input_i(aof), .set_value_i(sv),
    .offset_enable_i(oe), .func_gen_active_i(fg), .closed_loop_i(cl),
    .notch_enable_i(ne), .shape_lowpass_i(lp), .slew_step_i(ss),
    .notch_coef_i(nc), .proportional_gain_i(pgn),
    .integral_time_constant_i(itc), .derivative_time_constant_i(dtc),
    .gain_write_i(gw), .id_load_i(il), .id_proportional_gain_i(igp),
    .id_integral_time_constant_i(iit),
    .id_derivative_time_constant_i(idt), .dac_data_o(dac),
    .dac_valid_o(dv), .deviation_o(dev), .sample_tick_o(tk));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // inputs move just after an output, far from the next sample
  task automatic smp(input int n);
    repeat (n) @(posedge dv);
    @(posedge clk);
  endtask
  task automatic gains(input logic [15:0] p, input logic [15:0] i,
                       input logic [15:0] d);
    {pgn, itc, dtc, gw} <= {p, i, d, 1'b1};
    @(posedge clk);
    gw <= 1'b0;
  endtask
  // offset binary: top bits with the sign flipped
  function automatic logic [17:0] dx(input logic [23:0] y);
    return y[23:6] ^ 18'h2_0000;
  endfunction
  // converter word left-justified in the positive half of the path
  function automatic logic [23:0] wd(input logic [17:0] x);
    return {1'b0, x, 5'h00};
  endfunction
  initial
  begin
    {cl, lp, oe, fg, ne, gw, il} <= 7'h50;
    {sv, ss, sn, of} <= {24'h00_0000, 24'hFF_FFFF, 36'h0_0000_0000};
    {nc, pgn, itc, dtc, igp} <= {16'h0800, 16'h1000, 32'h0000_0000, 16'h2000};
    {iit, idt} <= {16'h0100, 16'h1000};
    void'($urandom(32'ha64a));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6)
    begin
      s = 24'($urandom_range(24'h1F_FFFF) - 24'h10_0000);
      // top bit clear keeps offset plus set value inside the signed range
      pd = {1'b0, 17'($urandom)};
      {sv, sn, of} <= {s, pd, pd};
      smp(2);
      chk(dev, s);
      chk(dac, dx(s));
    end
    {sn, of, sv, oe} <= {18'h0_0000, 18'h1_0000, 24'h00_1000, 1'b0};
    smp(2);
    chk(dev, 24'h00_1000);
    {oe, fg} <= 2'h3;
    smp(2);
    chk(dev, 24'h00_1000);
    fg <= 1'b0;
    smp(2);
    chk(dev, 24'(wd(18'h1_0000) + 24'h00_1000));
    {cl, sn, of, sv} <= {1'b0, 18'h2_5555, 18'h0_0000, 24'hFF_0000};
    smp(2);
    chk(dac, dx(24'hFF_0000));
    gains(16'h0000, 16'h1000, 16'h0000);
    {cl, sn, sv} <= {1'b1, 18'h0_0000, 24'h00_1000};
    smp(2);
    repeat (3)
    begin
      pd = dac;
      smp(1);
      chk(18'(dac - pd), 18'h0_0040);
    end
    cl <= 1'b0;
    smp(1);
    gains(16'h0000, 16'h0000, 16'h1000);
    {cl, sv} <= {1'b1, 24'h00_0000};
    smp(2);
    sv <= 24'h00_4000;
    smp(1);
    chk(dac, dx(24'h00_4000));
    smp(1);
    chk(dac, dx(24'h00_0000));
    {il, sv} <= {1'b1, 24'h00_2000};
    @(posedge clk);
    il <= 1'b0;
    smp(1);
    chk(dac, dx(24'h00_2200));
    smp(1);
    chk(dac, dx(24'h00_4400));
    gains(16'h1000, 16'h0000, 16'h0000);
    smp(2);
    chk(dac, dx(24'h00_2400));
    {ss, sv} <= {24'h00_0100, 24'h00_3000};
    for (int k = 1; k < 5; k++)
    begin
      smp(1);
      chk(dev, 24'(24'h00_2000 + k * 256));
    end
    {ss, lp, sv} <= {24'hFF_FFFF, 1'b1, 24'h00_8000};
    smp(1);
    chk(dev === 24'h00_8000, 1'b0);
    smp(150);
    chk(24'(dev - 24'h00_7F00) < 24'h00_0200, 1'b1);
    {lp, ne, sv} <= {1'b0, 1'b1, 24'h00_4000};
    smp(1);
    chk(dev === 24'h00_4000, 1'b0);
    smp(4);
    chk(dev, 24'h00_4000);
    {cl, sv} <= {1'b0, 24'h00_0000};
    smp(1);
    chk(dac === dx(24'h00_0000), 1'b0);
    smp(4);
    chk(dac, dx(24'h00_0000));
    end_sim();
  end
  initial
  begin
    #2_000_000;
    miscompares++;
    end_sim();
  end
endmodule
